// ===== hw/capmode_pkg.sv
// constants and codes for the capture/compare mode selection block
package capmode_pkg;
  // register byte offsets
  localparam logic [7:0] OFFSET_MODE = 8'h00;
  localparam logic [7:0] OFFSET_CONTROL = 8'h04;
  localparam logic [7:0] OFFSET_STAGED = 8'h08;
  localparam logic [7:0] OFFSET_STATUS = 8'h0c;
  localparam logic [7:0] OFFSET_CAPTURE0 = 8'h10;
  localparam logic [7:0] OFFSET_SHADOW0 = 8'h20;
  // mode register layout
  localparam int MODE_FIELD_WIDTH = 4;
  localparam int HSYNC_LSB = 12;
  localparam int DELAY_BYPASS_BIT = 15;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // control register layout
  localparam int SOFTWARE_HALL_TRIGGER_BIT = 0;
  localparam int DTLOAD_LSB = 8;
  localparam logic [5:0] DTLOAD_RESET = 6'h01;
  // status register layout
  localparam int STATUS_PATTERN_LSB = 4;
  localparam int STATUS_DTC_LSB = 8;
  // channel mode codes
  localparam logic [3:0] MODE_CMP_NONE = 4'h0;
  localparam logic [3:0] MODE_CMP_PIN = 4'h1;
  localparam logic [3:0] MODE_CMP_COMP = 4'h2;
  localparam logic [3:0] MODE_CMP_BOTH = 4'h3;
  localparam logic [3:0] MODE_DBL_SPLIT = 4'h4;
  localparam logic [3:0] MODE_DBL_RISE = 4'h5;
  localparam logic [3:0] MODE_DBL_FALL = 4'h6;
  localparam logic [3:0] MODE_DBL_ANY = 4'h7;
  localparam logic [3:0] MODE_HALL = 4'h8;
  localparam logic [3:0] MODE_HYST = 4'h9;
  localparam logic [3:0] MODE_MI_RF = 4'ha;
  localparam logic [3:0] MODE_MI_FR = 4'hb;
  localparam logic [3:0] MODE_MI_RR = 4'hc;
  localparam logic [3:0] MODE_MI_FF = 4'hd;
  localparam logic [3:0] MODE_MI_AA = 4'he;
  localparam logic [3:0] MODE_RESERVED = 4'hf;
  // hall sampling source codes
  localparam logic [2:0] HSYNC_POS_EDGE = 3'h0;
  localparam logic [2:0] HSYNC_SEC_MATCH = 3'h1;
  localparam logic [2:0] HSYNC_SEC_PERIOD = 3'h2;
  localparam logic [2:0] HSYNC_OFF = 3'h3;
  localparam logic [2:0] HSYNC_MAIN_PERIOD = 3'h4;
  localparam logic [2:0] HSYNC_MAIN_ONE = 3'h5;
  localparam logic [2:0] HSYNC_CH1_UP = 3'h6;
  localparam logic [2:0] HSYNC_CH1_DOWN = 3'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/capture_channel.sv
// one capture/compare channel: capture, shadow, state bit and pin drive
module capture_channel
  import capmode_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [3:0] mode_in,
  input wire logic [15:0] timer_value_in,
  input wire logic pin_rise_in,
  input wire logic pin_fall_in,
  input wire logic pos_rise_in,
  input wire logic pos_fall_in,
  input wire logic pos_level_in,
  input wire logic compare_match_in,
  input wire logic compare_clear_in,
  input wire logic hall_capture_in,
  output logic [15:0] capture_out,
  output logic [15:0] shadow_out,
  output logic state_out,
  output logic pin_level_out,
  output logic pin_oe_out,
  output logic comp_level_out,
  output logic comp_oe_out,
  output logic deadtime_start_out
);
  // modes in which the state bit follows compare events
  function automatic logic is_compare(input logic [3:0] mode);
    is_compare = (mode <= MODE_CMP_BOTH) || (mode == MODE_HALL) || (mode == MODE_HYST);
  endfunction

  // capture and shadow registers per mode
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      capture_out <= 16'h0000;
      shadow_out <= 16'h0000;
    end
    else
    begin
      case (mode_in)
        MODE_DBL_SPLIT:
        begin
          if (pin_rise_in) capture_out <= timer_value_in;
          if (pin_fall_in) shadow_out <= timer_value_in;
        end
        MODE_DBL_RISE, MODE_DBL_FALL, MODE_DBL_ANY:
        begin
          if ((pin_rise_in && mode_in != MODE_DBL_FALL) || (pin_fall_in && mode_in != MODE_DBL_RISE))
          begin
            capture_out <= shadow_out;
            shadow_out <= timer_value_in;
          end
        end
        MODE_HALL:
          if (hall_capture_in) capture_out <= timer_value_in;
        MODE_MI_RF, MODE_MI_FR, MODE_MI_RR, MODE_MI_FF, MODE_MI_AA:
        begin
          if ((pin_rise_in && mode_in != MODE_MI_FR && mode_in != MODE_MI_FF)
              || (pin_fall_in && mode_in != MODE_MI_RF && mode_in != MODE_MI_RR))
            capture_out <= timer_value_in;
          if ((pos_rise_in && mode_in != MODE_MI_RF && mode_in != MODE_MI_FF)
              || (pos_fall_in && mode_in != MODE_MI_FR && mode_in != MODE_MI_RR))
            shadow_out <= timer_value_in;
        end
        default: ; // compare and reserved codes capture nothing
      endcase
    end
  end

  // state bit: set by compare, cleared by clear event or position fall
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      state_out <= 1'b0;
    else if (is_compare(mode_in) && compare_match_in && (mode_in != MODE_HYST || pos_level_in))
      state_out <= 1'b1;
    else if (mode_in == MODE_HYST && pos_fall_in)
      state_out <= 1'b0;
    else if (is_compare(mode_in) && compare_clear_in)
      state_out <= 1'b0;
  end

  // pin drive and dead-time start
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_level_out <= 1'b0;
      comp_level_out <= 1'b1;
      pin_oe_out <= 1'b0;
      comp_oe_out <= 1'b0;
      deadtime_start_out <= 1'b0;
    end
    else
    begin
      pin_level_out <= state_out;
      comp_level_out <= ~state_out;
      pin_oe_out <= (mode_in == MODE_CMP_PIN) || (mode_in == MODE_CMP_BOTH) || (mode_in == MODE_HYST);
      comp_oe_out <= (mode_in == MODE_CMP_COMP) || (mode_in == MODE_CMP_BOTH) || (mode_in == MODE_HYST);
      deadtime_start_out <= (mode_in == MODE_HYST) && compare_match_in && pos_level_in && !state_out;
    end
  end
endmodule // capture_channel

// ===== hw/hall_sampler.sv
// hall sampling trigger select, noise delay and pattern compare
module hall_sampler
  import capmode_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic hall_enable_in,
  input wire logic [2:0] source_in,
  input wire logic bypass_in,
  input wire logic [5:0] delay_load_in,
  input wire logic [2:0] position_in,
  input wire logic position_edge_in,
  input wire logic [5:0] match_events_in,
  input wire logic software_trigger_in,
  output logic [2:0] pattern_out,
  output logic hall_event_out,
  output logic [5:0] deadtime_count_out
);
  typedef enum logic {HALL_IDLE, HALL_DELAY} hall_state_t;
  hall_state_t state;
  logic trigger;
  logic sample_now;

  // source selection, software trigger works in every setting
  always_comb
  begin
    case (source_in)
      HSYNC_POS_EDGE: trigger = position_edge_in && hall_enable_in;
      HSYNC_OFF: trigger = 1'b0;
      default: trigger = match_events_in[source_in - 3'h1 - {2'b00, source_in[2]}];
    endcase
    trigger = trigger || software_trigger_in;
    sample_now = 1'b0;
    case (state)
      HALL_IDLE: sample_now = trigger && (bypass_in || delay_load_in <= 6'h01);
      HALL_DELAY: sample_now = (deadtime_count_out == 6'h01);
      default: sample_now = 1'b0;
    endcase
  end

  // dead-time counter counting down to one as noise delay
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= HALL_IDLE;
      deadtime_count_out <= 6'h00;
    end
    else
    begin
      case (state)
        HALL_IDLE:
          if (trigger && !sample_now)
          begin
            state <= HALL_DELAY;
            deadtime_count_out <= delay_load_in;
          end
        HALL_DELAY:
          if (sample_now)
            state <= HALL_IDLE;
          else
            deadtime_count_out <= deadtime_count_out - 6'h01;
        default: state <= HALL_IDLE;
      endcase
    end
  end

  // sample pattern; a changed pattern is a valid hall event
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pattern_out <= 3'h0;
      hall_event_out <= 1'b0;
    end
    else
    begin
      hall_event_out <= sample_now && hall_enable_in && (position_in != pattern_out);
      if (sample_now)
        pattern_out <= position_in;
    end
  end
endmodule // hall_sampler

// ===== hw/pwm_timer_capture_mode_select.sv
// capture/compare mode selection with axi4-lite register access
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module pwm_timer_capture_mode_select
  import capmode_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic [15:0] timer_value_in,
  input wire logic timer_running_in,
  input wire logic transfer_event_in,
  input wire logic [2:0] channel_pin_in,
  input wire logic [2:0] position_input_in,
  input wire logic [2:0] compare_match_in,
  input wire logic [2:0] compare_clear_in,
  input wire logic secondary_compare_in,
  input wire logic secondary_period_in,
  input wire logic main_period_up_in,
  input wire logic main_one_down_in,
  input wire logic ch1_match_up_in,
  input wire logic ch1_match_down_in,
  output logic [2:0] channel_pin_out,
  output logic [2:0] channel_pin_oe_out,
  output logic [2:0] complementary_output_pin_out,
  output logic [2:0] complementary_output_pin_oe_out,
  output logic [2:0] deadtime_start_out,
  output logic [2:0] hall_pattern_out,
  output logic timer_reset_out,
  output logic phase_delay_out,
  output logic hall_timeout_out
);
  // register state
  logic [15:0] capture_compare_mode_select;
  logic [15:0] staged_mode;
  logic mode_pending;
  logic [5:0] deadtime_load;
  logic software_hall_trigger;

  // bus slave state
  logic aw_held;
  logic w_held;
  logic [7:0] write_addr;
  logic [31:0] write_data;
  logic [3:0] write_strb;
  logic write_fire;
  logic [31:0] staged_merge;

  // input synchronisers
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [2:0] pos_meta;
  logic [2:0] pos_sync;
  logic [2:0] pos_prev;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic [2:0] pos_rise;
  logic [2:0] pos_fall;

  // channel results
  logic [15:0] capture_value [3];
  logic [15:0] shadow_value [3];
  logic [2:0] state_bits;
  logic [2:0] chan_pin_level;
  logic [2:0] chan_pin_oe;
  logic [2:0] chan_comp_level;
  logic [2:0] chan_comp_oe;
  logic [2:0] chan_deadtime;

  // hall results
  logic hall_mode;
  logic hall_event;
  logic [2:0] hall_pattern;
  logic [5:0] deadtime_count;
  logic [31:0] read_value;
  logic read_hit;

  // mode field of one channel
  function automatic logic [3:0] channel_mode_field(input logic [15:0] reg_value, input int index);
    channel_mode_field = reg_value[index * MODE_FIELD_WIDTH +: MODE_FIELD_WIDTH];
  endfunction

  // merge written bytes into a 32-bit value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value, input logic [31:0] new_value,
                                              input logic [3:0] strb);
    logic [31:0] result;
    result = old_value;
    for (int b = 0; b < 4; b++)
      if (strb[b]) result[b * 8 +: 8] = new_value[b * 8 +: 8];
    merge_bytes = result;
  endfunction

  // two-flop synchronisers plus one flop for edge detection
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
      pos_meta <= 3'h0;
      pos_sync <= 3'h0;
      pos_prev <= 3'h0;
    end
    else
    begin
      pin_meta <= channel_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      pos_meta <= position_input_in;
      pos_sync <= pos_meta;
      pos_prev <= pos_sync;
    end
  end

  // edge detection on synchronised levels
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;
  assign pos_rise = pos_sync & ~pos_prev;
  assign pos_fall = ~pos_sync & pos_prev;

  // hall detection needs all three fields in hall mode
  assign hall_mode = (channel_mode_field(capture_compare_mode_select, 0) == MODE_HALL)
                     && (channel_mode_field(capture_compare_mode_select, 1) == MODE_HALL)
                     && (channel_mode_field(capture_compare_mode_select, 2) == MODE_HALL);

  // write address channel
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      aw_held <= 1'b0;
      s_axi_awready_out <= 1'b1;
      write_addr <= 8'h00;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_held <= 1'b1;
      s_axi_awready_out <= 1'b0;
      write_addr <= s_axi_awaddr_in;
    end
    else if (s_axi_bvalid_out && s_axi_bready_in)
    begin
      aw_held <= 1'b0;
      s_axi_awready_out <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      w_held <= 1'b0;
      s_axi_wready_out <= 1'b1;
      write_data <= 32'h0000_0000;
      write_strb <= 4'h0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_held <= 1'b1;
      s_axi_wready_out <= 1'b0;
      write_data <= s_axi_wdata_in;
      write_strb <= s_axi_wstrb_in;
    end
    else if (s_axi_bvalid_out && s_axi_bready_in)
    begin
      w_held <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end
  end

  assign write_fire = aw_held && w_held && !s_axi_bvalid_out;
  // staged word with the written bytes merged in
  assign staged_merge = merge_bytes({16'h0000, staged_mode}, write_data, write_strb);

  // write response, error for every offset except staged and control
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end
    else if (write_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      if (write_addr == OFFSET_STAGED || write_addr == OFFSET_CONTROL)
        s_axi_bresp_out <= RESP_OKAY;
      else
        s_axi_bresp_out <= RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // mode staging and concurrent commit
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      staged_mode <= MODE_RESET;
      mode_pending <= 1'b0;
      capture_compare_mode_select <= MODE_RESET;
    end
    else
    begin
      if (mode_pending && (transfer_event_in || !timer_running_in))
        capture_compare_mode_select <= staged_mode;
      if (write_fire && write_addr == OFFSET_STAGED)
      begin
        staged_mode <= staged_merge[15:0];
        mode_pending <= 1'b1; // a new write wins over the commit
      end
      else if (transfer_event_in || !timer_running_in)
        mode_pending <= 1'b0;
    end
  end

  // control: delay load and software hall trigger pulse
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      deadtime_load <= DTLOAD_RESET;
      software_hall_trigger <= 1'b0;
    end
    else
    begin
      software_hall_trigger <= write_fire && write_addr == OFFSET_CONTROL
                               && write_strb[0] && write_data[SOFTWARE_HALL_TRIGGER_BIT];
      if (write_fire && write_addr == OFFSET_CONTROL && write_strb[1])
        deadtime_load <= write_data[DTLOAD_LSB +: 6];
    end
  end

  // read decode
  always_comb
  begin
    read_hit = 1'b1;
    read_value = 32'h0000_0000;
    case (s_axi_araddr_in)
      OFFSET_MODE: read_value = {16'h0000, capture_compare_mode_select};
      OFFSET_CONTROL: read_value = {18'h00000, deadtime_load, 8'h00};
      OFFSET_STAGED: read_value = {15'h0000, mode_pending, staged_mode};
      OFFSET_STATUS: read_value = {18'h00000, deadtime_count, 1'b0, hall_pattern, 1'b0, state_bits};
      OFFSET_CAPTURE0: read_value = {16'h0000, capture_value[0]};
      OFFSET_CAPTURE0 + 8'h04: read_value = {16'h0000, capture_value[1]};
      OFFSET_CAPTURE0 + 8'h08: read_value = {16'h0000, capture_value[2]};
      OFFSET_SHADOW0: read_value = {16'h0000, shadow_value[0]};
      OFFSET_SHADOW0 + 8'h04: read_value = {16'h0000, shadow_value[1]};
      OFFSET_SHADOW0 + 8'h08: read_value = {16'h0000, shadow_value[2]};
      default: read_hit = 1'b0;
    endcase
  end

  // read channel, data one cycle after address taken
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= read_value;
      s_axi_rresp_out <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // three independent channels
  for (genvar n = 0; n < 3; n++)
  begin : gen_channel
    capture_channel channel
    (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .mode_in(channel_mode_field(capture_compare_mode_select, n)),
      .timer_value_in(timer_value_in),
      .pin_rise_in(pin_rise[n]),
      .pin_fall_in(pin_fall[n]),
      .pos_rise_in(pos_rise[n]),
      .pos_fall_in(pos_fall[n]),
      .pos_level_in(pos_sync[n]),
      .compare_match_in(compare_match_in[n]),
      .compare_clear_in(compare_clear_in[n]),
      .hall_capture_in(n == 0 ? hall_event : 1'b0),
      .capture_out(capture_value[n]),
      .shadow_out(shadow_value[n]),
      .state_out(state_bits[n]),
      .pin_level_out(chan_pin_level[n]),
      .pin_oe_out(chan_pin_oe[n]),
      .comp_level_out(chan_comp_level[n]),
      .comp_oe_out(chan_comp_oe[n]),
      .deadtime_start_out(chan_deadtime[n])
    );
  end

  // hall sampling path
  hall_sampler hall
  (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .hall_enable_in(hall_mode),
    .source_in(capture_compare_mode_select[HSYNC_LSB +: 3]),
    .bypass_in(capture_compare_mode_select[DELAY_BYPASS_BIT]),
    .delay_load_in(deadtime_load),
    .position_in(pos_sync),
    .position_edge_in(|(pos_rise | pos_fall)),
    .match_events_in({ch1_match_down_in, ch1_match_up_in, main_one_down_in, main_period_up_in,
                      secondary_period_in, secondary_compare_in}),
    .software_trigger_in(software_hall_trigger),
    .pattern_out(hall_pattern),
    .hall_event_out(hall_event),
    .deadtime_count_out(deadtime_count)
  );

  // registered pin outputs
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      channel_pin_out <= 3'h0;
      channel_pin_oe_out <= 3'h0;
      complementary_output_pin_out <= 3'h0;
      complementary_output_pin_oe_out <= 3'h0;
      deadtime_start_out <= 3'h0;
      hall_pattern_out <= 3'h0;
    end
    else
    begin
      channel_pin_out <= chan_pin_level;
      channel_pin_oe_out <= chan_pin_oe;
      complementary_output_pin_out <= chan_comp_level;
      complementary_output_pin_oe_out <= chan_comp_oe;
      deadtime_start_out <= chan_deadtime;
      hall_pattern_out <= hall_pattern;
    end
  end

  // hall mode timer reset, phase delay and time-out
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      timer_reset_out <= 1'b0;
      phase_delay_out <= 1'b0;
      hall_timeout_out <= 1'b0;
    end
    else
    begin
      timer_reset_out <= hall_event && hall_mode;
      phase_delay_out <= hall_mode && compare_match_in[1];
      hall_timeout_out <= hall_mode && compare_match_in[2];
    end
  end
endmodule // pwm_timer_capture_mode_select

// ===== tb/capmode_checker.sv
// concurrent checks on the capture mode select ports
module capmode_checker
  import capmode_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [2:0] compare_match_in,
  input wire logic timer_reset_out,
  input wire logic phase_delay_out,
  input wire logic hall_timeout_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // bus answers stand until taken
  chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response changed before taken");
  chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data changed before taken");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");
  chk_bvalid_drop: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response repeated");
  chk_rvalid_drop: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answer repeated");
  // phase delay and time-out follow their compares, timer reset lasts one cycle
  chk_phase_delay: assert property (phase_delay_out |-> $past(compare_match_in[1]))
    else $error("phase delay without channel 1 compare");
  chk_hall_timeout: assert property (hall_timeout_out |-> $past(compare_match_in[2]))
    else $error("time-out without channel 2 compare");
  chk_reset_pulse: assert property (timer_reset_out |=> !timer_reset_out)
    else $error("timer reset longer than one cycle");
  cover property (timer_reset_out);
  cover property (phase_delay_out && hall_timeout_out);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule // capmode_checker
bind pwm_timer_capture_mode_select capmode_checker chk (.*);

// ===== tb/far_side_model.sv
// channel pins and hall sensors facing the block
module far_side_model
(
  input wire logic clock_in,
  input wire logic [2:0] pin_req_in,
  input wire logic [2:0] hall_req_in,
  output logic [2:0] pin_out,
  output logic [2:0] hall_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // sensors and drivers change just after an edge
  always_ff @(posedge clock_in)
  begin
    pin_out <= pin_req_in;
    hall_out <= hall_req_in;
  end
endmodule // far_side_model

// ===== tb/pwm_timer_capture_mode_select_test.sv
// self-checking bench for the capture mode select block
module pwm_timer_capture_mode_select_test import capmode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv, trd, pd, ht;
  logic [7:0] awa = 0, ara = 0, misc = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [1:0] br, rr, resp;
  logic [15:0] tv = 0;
  logic [2:0] pin = 0, pos = 0, cm = 0, cpin, cpos, hp;
  int err_count = 0, cmp_count = 0;
  far_side_model fsm (.clock_in(clk), .pin_req_in(pin), .hall_req_in(pos), .pin_out(cpin), .hall_out(cpos));
  pwm_timer_capture_mode_select uut (.clock_in(clk), .reset_in(rst), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
    .timer_value_in(tv), .timer_running_in(misc[0]), .transfer_event_in(misc[1]), .channel_pin_in(cpin),
    .position_input_in(cpos), .compare_match_in(cm), .compare_clear_in(3'h0), .secondary_compare_in(misc[2]),
    .secondary_period_in(misc[3]), .main_period_up_in(misc[4]), .main_one_down_in(misc[5]), .ch1_match_up_in(misc[6]),
    .ch1_match_down_in(misc[7]), .channel_pin_out(), .channel_pin_oe_out(), .complementary_output_pin_out(),
    .complementary_output_pin_oe_out(), .deadtime_start_out(), .hall_pattern_out(hp), .timer_reset_out(trd),
    .phase_delay_out(pd), .hall_timeout_out(ht));
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task tmo(input int n);
    if (n >= 60)
    begin
      err_count++;
      print_verdict;
    end
  endtask
  // one write: address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int n;
    logic sa, sw, sb;
    sb = 0;
    @(posedge clk);
    awa <= a;
    wd <= x;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    for (n = 0; n < 60 && !sb; n++)
    begin
      @(negedge clk);
      sa = awv && awr;
      sw = wv && wrd;
      sb = bre && bv;
      resp = br;
      @(posedge clk);
      if (sa) awv <= 0;
      if (sw) wv <= 0;
      if (sb) bre <= 0;
    end
    tmo(sb ? 0 : n);
  endtask
  // one read: rready held until the answer
  task automatic rd(input logic [7:0] a);
    int n;
    logic sa, sb;
    sb = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    for (n = 0; n < 60 && !sb; n++)
    begin
      @(negedge clk);
      sa = arv && arr;
      sb = rre && rv;
      d = rdat;
      resp = rr;
      @(posedge clk);
      if (sa) arv <= 0;
      if (sb) rre <= 0;
    end
    tmo(sb ? 0 : n);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("read", e, d);
  endtask
  task cyc(input logic [15:0] t, input logic [2:0] p);
    tv <= t;
    pin <= p;
    repeat (6) @(posedge clk);
  endtask
  initial forever #12.5 clk = ~clk;
  // main sequence
  initial
  begin : main
    int n;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(OFFSET_MODE, 32'h0);
    wr(OFFSET_STAGED, 32'h0745);
    rc(OFFSET_MODE, 32'h0745);
    cyc(16'h1111, 3'h7);
    cyc(16'h2222, 3'h0);
    cyc(16'h3333, 3'h7);
    rc(OFFSET_CAPTURE0, 32'h1111);
    rc(OFFSET_SHADOW0, 32'h3333);
    rc(OFFSET_CAPTURE0 + 8'h04, 32'h3333);
    rc(OFFSET_SHADOW0 + 8'h04, 32'h2222);
    rc(OFFSET_CAPTURE0 + 8'h08, 32'h2222);
    rc(OFFSET_SHADOW0 + 8'h08, 32'h3333);
    wr(OFFSET_STAGED, 32'h0fff);
    cyc(16'h4444, 3'h0);
    rc(OFFSET_CAPTURE0, 32'h1111);
    rc(OFFSET_SHADOW0 + 8'h08, 32'h3333);
    wr(OFFSET_MODE, 32'h0);
    chk("resp", RESP_SLVERR, resp);
    rd(8'h40);
    chk("resp", RESP_SLVERR, resp);
    wr(OFFSET_STAGED, 32'h8888); // all three fields in hall mode
    tv <= 16'h5555;
    pos <= 3'h5;
    for (n = 0; n < 60 && trd !== 1'b1; n++) @(negedge clk);
    tmo(trd === 1'b1 ? 0 : n);
    chk("pattern", 32'h5, {29'h0, hp});
    rc(OFFSET_CAPTURE0, 32'h5555);
    @(posedge clk);
    cm <= 3'h6;
    @(posedge clk);
    cm <= 3'h0;
    @(negedge clk);
    chk("hall compare", 32'h3, {30'h0, pd, ht});
    // running timer: staged mode waits for the transfer event
    @(posedge clk);
    misc <= 8'h01;
    wr(OFFSET_STAGED, 32'h0);
    rc(OFFSET_MODE, 32'h8888);
    misc <= 8'h03;
    @(posedge clk);
    misc <= 8'h01;
    rc(OFFSET_MODE, 32'h0);
    print_verdict;
  end
endmodule // pwm_timer_capture_mode_select_test
